// File: mmd_checker.sv
/* Concurrent checks on the decoder top ports.
   Assumes APB byte address four times the index, placement at 0xf4. */
`timescale 1ns/1ps
module mmd_checker
   import mmd_pkg::*;
(
   // Clock and reset
   input wire logic        SYS_CLK,
   input wire logic        SYS_RST,
   // APB
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   // Decode
   input wire logic [15:0] CORE_ADDR,
   input wire logic        SEL_REGS,
   input wire logic        SEL_RAM,
   input wire logic        SEL_ROM,
   input wire logic        SEL_EXT,
   input wire logic        SEL_NONE,
   input wire logic [7:0]  LOCAL_OFFSET,
   // Timer controls and mode
   input wire logic [4:0]  FORCE_COMPARE_BIT,
   input wire logic [4:0]  COMPARE1_MASK,
   input wire logic [1:0]  MODE_LATCHED
);
   logic [7:0]  place_q;
   logic [15:0] a_q;
   logic [4:0]  wd_q;
   logic        live_q, live2_q, reg_q, ram_q, rom_q;
   wire         wr = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
   wire         rd = PSEL && PENABLE && PREADY && !PWRITE;
   wire         off = live2_q && !reg_q && !ram_q && !rom_q;

   // Placement tracking and window hits of the last core address.
   always_ff @(posedge SYS_CLK) begin
      a_q <= CORE_ADDR;
      wd_q <= PWDATA[7:3];
      reg_q <= CORE_ADDR[15:12] == place_q[3:0] && CORE_ADDR[11:6] == 6'h00;
      ram_q <= CORE_ADDR[15:12] == place_q[7:4] && CORE_ADDR[11:8] == 4'h0
               && CORE_ADDR[7:6] != 2'h0;
      rom_q <= CORE_ADDR[15:8] == 8'hbf;
      if (SYS_RST) begin
         place_q <= 8'h00;
         live_q <= 1'b0;
         live2_q <= 1'b0;
      end else begin
         live_q <= 1'b1;
         live2_q <= live_q;
         if (wr && PADDR == 8'hf4) place_q <= PWDATA[7:0];
      end
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);

   reg_window_a: assert property (live2_q && reg_q |->
      SEL_REGS && LOCAL_OFFSET == {2'h0, a_q[5:0]})
      else $error("register window decode wrong");
   ram_window_a: assert property (live2_q && ram_q && !reg_q |->
      SEL_RAM && LOCAL_OFFSET == a_q[7:0] - 8'h40)
      else $error("ram window decode wrong");
   ext_mode_a: assert property (off && $stable(MODE_LATCHED) |->
      SEL_EXT == MODE_LATCHED[0])
      else $error("external select disagrees with mode");
   none_single_a: assert property (off && $stable(MODE_LATCHED) && !MODE_LATCHED[0] |->
      SEL_NONE && LOCAL_OFFSET == 8'h00)
      else $error("unmapped address not refused");
   rom_boot_a: assert property (live2_q && rom_q && !reg_q && !ram_q &&
      $stable(MODE_LATCHED) |-> SEL_ROM == (MODE_LATCHED == 2'h0))
      else $error("boot rom select disagrees with mode");
   one_target_a: assert property (live2_q |->
      $onehot({SEL_REGS, SEL_RAM, SEL_ROM, SEL_EXT, SEL_NONE}))
      else $error("not exactly one target selected");
   force_pulse_a: assert property (wr && PADDR == 8'h2c |=>
      FORCE_COMPARE_BIT == wd_q)
      else $error("force bits not pulsed from write");
   force_read_a: assert property (rd && PADDR == 8'h2c |->
      PRDATA == 32'h0)
      else $error("force register read not zero");
   mask_write_a: assert property (wr && PADDR == 8'h30 |=>
      COMPARE1_MASK == wd_q)
      else $error("mask bits not taken from write");
   mask_read_a: assert property (rd && PADDR == 8'h30 |->
      PRDATA == {24'h0, COMPARE1_MASK, 3'h0})
      else $error("mask read layout wrong");

   cover property (live2_q && reg_q && place_q[3:0] != 4'h0);
   cover property (SEL_ROM);
   cover property (SEL_EXT);
endmodule : mmd_checker

bind mmd_top mmd_checker mmd_checker_inst (.SYS_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE,
   .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CORE_ADDR, .SEL_REGS, .SEL_RAM,
   .SEL_ROM, .SEL_EXT, .SEL_NONE, .LOCAL_OFFSET, .FORCE_COMPARE_BIT, .COMPARE1_MASK,
   .MODE_LATCHED);

// File: mmd_core_model.sv
/* Processor core model: issues one address per call.
   Assumes the decoder samples the address on every rising edge. */
`timescale 1ns/1ps
module mmd_core_model (
   // Clock
   input wire logic  clk,
   // Address to the decoder
   output logic [15:0] core_addr
);
   initial core_addr = 16'h0000;

   task automatic issue(input logic [15:0] a);
      @(posedge clk);
      core_addr <= a;
   endtask : issue
endmodule : mmd_core_model

// File: mmd_dec_if.sv
/*
 * Carries one core address and the placement and mode to the decoder,
 * and the decoded target back. Assumes a purely combinational decoder.
 */
`timescale 1ns/1ps
interface mmd_dec_if;
   import mmd_pkg::*;
   logic [15:0] addr;
   logic [3:0]  ram_page;
   logic [3:0]  reg_page;
   mmd_mode_e   mode;
   logic        hit_regs;
   logic        hit_ram;
   logic        hit_rom;
   logic        hit_ext;
   logic [7:0]  offset;
   modport src  (output addr, ram_page, reg_page, mode,
                 input hit_regs, hit_ram, hit_rom, hit_ext, offset);
   modport sink (input addr, ram_page, reg_page, mode,
                 output hit_regs, hit_ram, hit_rom, hit_ext, offset);
endinterface : mmd_dec_if

// File: mmd_decode.sv
/*
 * Combinational address decoder for the 64 Kbyte space.
 * Assumes placement pages and the latched mode come from the top.
 */
`timescale 1ns/1ps
module mmd_decode
   import mmd_pkg::*;
(
   // Decode request and result
   mmd_dec_if.sink dec
);
   logic in_regs;
   logic in_ram;
   logic in_rom;
   logic expanded;

   always_comb begin
      in_regs  = (dec.addr[15:12] == dec.reg_page) && (dec.addr[11:6] == REG_SPAN_HI);
      in_ram   = (dec.addr[15:12] == dec.ram_page) && (dec.addr[11:0] >= RAM_LOW_FIRST)
                 && (dec.addr[11:0] <= RAM_LOW_LAST);
      in_rom   = (dec.mode == MODE_BOOT) && (dec.addr[15:8] == ROM_PAGE);
      expanded = (dec.mode == MODE_EXPANDED) || (dec.mode == MODE_TEST);
      dec.hit_regs = 1'b0;
      dec.hit_ram  = 1'b0;
      dec.hit_rom  = 1'b0;
      dec.hit_ext  = 1'b0;
      dec.offset   = 8'h00;
      if (in_regs) begin
         dec.hit_regs = 1'b1;
         dec.offset   = {2'b00, dec.addr[5:0]};
      end else if (in_ram) begin
         dec.hit_ram = 1'b1;
         dec.offset  = 8'(dec.addr[11:0] - RAM_LOW_FIRST);
      end else if (in_rom) begin
         dec.hit_rom = 1'b1;
         dec.offset  = dec.addr[7:0];
      end else if (expanded) begin
         dec.hit_ext = 1'b1;
         dec.offset  = dec.addr[7:0];
      end
   end
endmodule : mmd_decode

// File: mmd_pkg.sv
/*
 * Shared constants and types for the memory map decoder: register
 * indices, field positions, address windows, mode codes.
 * Assumes a single 100 MHz clock and an APB register bus.
 */
// Notes on behaviour
// - Reset-latched mode selects map and external access
// - Same on-chip addresses in single and expanded
// - RAM of 192 bytes at 0x0040 after reset
// - Placement moves RAM to page offset 0x040
// - Register block of 64 bytes at 0x0000
// - Placement moves register block to page start
// - Force bits 7..3, all bits 7..0 read zero
// - Mask bits 7..3, bits 2..0 read zero
// - Counter high byte, then low byte next
// - Capture high byte, then low byte next
package mmd_pkg;

   /************************************************
    * Modes
    ************************************************/
   typedef enum logic [1:0] {
      MODE_BOOT,
      MODE_TEST,
      MODE_SINGLE,
      MODE_EXPANDED
   } mmd_mode_e;

   localparam logic [1:0] PINS_BOOT     = 2'h0;
   localparam logic [1:0] PINS_TEST     = 2'h1;
   localparam logic [1:0] PINS_SINGLE   = 2'h2;
   localparam logic [1:0] PINS_EXPANDED = 2'h3;
   localparam logic [1:0] MODE_SETTLE   = 2'h3;

   /************************************************
    * Address windows
    ************************************************/
   localparam logic [11:0] RAM_LOW_FIRST = 12'h040;
   localparam logic [11:0] RAM_LOW_LAST  = 12'h0ff;
   localparam logic [5:0]  REG_SPAN_HI   = 6'h00;
   localparam logic [7:0]  ROM_PAGE      = 8'hbf;
   localparam logic [3:0]  RESET_PAGE    = 4'h0;

   /************************************************
    * Register indices; byte address is four times the index
    ************************************************/
   localparam logic [5:0] IDX_PORT_A    = 6'h00;
   localparam logic [5:0] IDX_PORT_C    = 6'h03;
   localparam logic [5:0] IDX_PORT_B    = 6'h04;
   localparam logic [5:0] IDX_DIR_B     = 6'h06;
   localparam logic [5:0] IDX_DIR_C     = 6'h07;
   localparam logic [5:0] IDX_PORT_D    = 6'h08;
   localparam logic [5:0] IDX_DIR_D     = 6'h09;
   localparam logic [5:0] IDX_FORCE     = 6'h0b;
   localparam logic [5:0] IDX_CMP_MASK  = 6'h0c;
   localparam logic [5:0] IDX_CMP_DATA  = 6'h0d;
   localparam logic [5:0] IDX_COUNT_HI  = 6'h0e;
   localparam logic [5:0] IDX_COUNT_LO  = 6'h0f;
   localparam logic [5:0] IDX_CAP1_HI   = 6'h10;
   localparam logic [5:0] IDX_CAP1_LO   = 6'h11;
   localparam logic [5:0] IDX_CAP2_HI   = 6'h12;
   localparam logic [5:0] IDX_CAP2_LO   = 6'h13;
   localparam logic [5:0] IDX_MODE_STAT = 6'h3c;
   localparam logic [5:0] IDX_PLACEMENT = 6'h3d;

   /************************************************
    * Field layouts and reset values
    ************************************************/
   localparam int          CMP_LSB       = 3;
   localparam int          CMP_MSB       = 7;
   localparam int          RAM_PAGE_LSB  = 4;
   localparam logic [7:0]  PORT_RESET    = 8'h00;
   localparam logic [4:0]  CMP_RESET     = 5'h00;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;

endpackage : mmd_pkg

// File: mmd_sync.sv
/*
 * Two-stage synchroniser for a group of asynchronous levels.
 * Assumes the inputs come from pins outside the clock domain.
 */
`timescale 1ns/1ps
module mmd_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Levels
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } mmd_sync_s;

   mmd_sync_s st_q;
   mmd_sync_s st_d;

   always_comb begin
      st_d        = st_q;
      st_d.stage1 = async_in;
      st_d.stage2 = st_q.stage1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_out = st_q.stage2;
endmodule : mmd_sync

// File: mmd_top.sv
/*
 * Memory map decoder top: mode latch, placement register, on-chip
 * register block over APB, and registered decode of core addresses.
 * Assumes one 100 MHz clock and a synchronous active-high reset.
 */
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module mmd_top
   import mmd_pkg::*;
(
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        SYS_RST,
   // Mode select pins
   input  wire logic        MODE_A,
   input  wire logic        MODE_B,
   // Capture pins
   input  wire logic [1:0]  CAPTURE_IN,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output      logic [31:0] PRDATA,
   output      logic        PREADY,
   output      logic        PSLVERR,
   // Core address
   input  wire logic [15:0] CORE_ADDR,
   // Decoded target
   output      logic        SEL_REGS,
   output      logic        SEL_RAM,
   output      logic        SEL_ROM,
   output      logic        SEL_EXT,
   output      logic        SEL_NONE,
   output      logic [7:0]  LOCAL_OFFSET,
   // Port registers
   output      logic [7:0]  PORT_A_DATA,
   output      logic [7:0]  PORT_B_DATA,
   output      logic [7:0]  PORT_B_DIRECTION,
   output      logic [7:0]  PORT_C_DATA,
   output      logic [7:0]  PORT_C_DIRECTION,
   output      logic [7:0]  PORT_D_DATA,
   output      logic [7:0]  PORT_D_DIRECTION,
   // Timer controls and mode
   output      logic [4:0]  FORCE_COMPARE_BIT,
   output      logic [4:0]  COMPARE1_MASK,
   output      logic [4:0]  COMPARE1_DATA,
   output      logic [1:0]  MODE_LATCHED
);

   /************************************************
    * State
    ************************************************/
   typedef struct packed {
      logic [1:0]  settle;
      logic        mode_taken;
      mmd_mode_e   mode;
      logic [3:0]  ram_page;
      logic [3:0]  reg_page;
      logic [7:0]  port_a;
      logic [7:0]  port_b;
      logic [7:0]  dir_b;
      logic [7:0]  port_c;
      logic [7:0]  dir_c;
      logic [7:0]  port_d;
      logic [7:0]  dir_d;
      logic [4:0]  force_pulse;
      logic [4:0]  cmp_mask;
      logic [4:0]  cmp_data;
      logic [15:0] count;
      logic [15:0] cap1;
      logic [15:0] cap2;
      logic [1:0]  cap_prev;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        sel_regs;
      logic        sel_ram;
      logic        sel_rom;
      logic        sel_ext;
      logic        sel_none;
      logic [7:0]  offset;
   } mmd_top_s;

   mmd_top_s st_q;
   mmd_top_s st_d;

   logic [3:0] pins_sync;
   logic [5:0] idx;
   logic       aligned;
   logic       mapped;
   logic [7:0] rd_byte;
   logic [7:0] wr_byte;
   logic       setup;
   logic       wr_now;
   logic [1:0] cap_edge;

   /************************************************
    * Synchroniser and decoder
    ************************************************/
   mmd_sync #(
      .WIDTH    (4)
   ) u_sync (
      .clk      (SYS_CLK),
      .rst      (SYS_RST),
      .async_in ({CAPTURE_IN, MODE_B, MODE_A}),
      .sync_out (pins_sync)
   );

   mmd_dec_if dec_bus ();

   mmd_decode u_decode (
      .dec (dec_bus.sink)
   );

   assign dec_bus.addr     = CORE_ADDR;
   assign dec_bus.ram_page = st_q.ram_page;
   assign dec_bus.reg_page = st_q.reg_page;
   assign dec_bus.mode     = st_q.mode;

   /************************************************
    * Register read mux
    ************************************************/
   always_comb begin
      idx      = PADDR[7:2];
      aligned  = (PADDR[1:0] == 2'b00);
      wr_byte  = PWDATA[7:0];
      mapped   = 1'b1;
      rd_byte  = 8'h00;
      if (idx == IDX_PORT_A) begin
         rd_byte = st_q.port_a;
      end else if (idx == IDX_PORT_C) begin
         rd_byte = st_q.port_c;
      end else if (idx == IDX_PORT_B) begin
         rd_byte = st_q.port_b;
      end else if (idx == IDX_DIR_B) begin
         rd_byte = st_q.dir_b;
      end else if (idx == IDX_DIR_C) begin
         rd_byte = st_q.dir_c;
      end else if (idx == IDX_PORT_D) begin
         rd_byte = st_q.port_d;
      end else if (idx == IDX_DIR_D) begin
         rd_byte = st_q.dir_d;
      end else if (idx == IDX_FORCE) begin
         rd_byte = 8'h00;
      end else if (idx == IDX_CMP_MASK) begin
         rd_byte = {st_q.cmp_mask, 3'b000};
      end else if (idx == IDX_CMP_DATA) begin
         rd_byte = {st_q.cmp_data, 3'b000};
      end else if (idx == IDX_COUNT_HI) begin
         rd_byte = st_q.count[15:8];
      end else if (idx == IDX_COUNT_LO) begin
         rd_byte = st_q.count[7:0];
      end else if (idx == IDX_CAP1_HI) begin
         rd_byte = st_q.cap1[15:8];
      end else if (idx == IDX_CAP1_LO) begin
         rd_byte = st_q.cap1[7:0];
      end else if (idx == IDX_CAP2_HI) begin
         rd_byte = st_q.cap2[15:8];
      end else if (idx == IDX_CAP2_LO) begin
         rd_byte = st_q.cap2[7:0];
      end else if (idx == IDX_MODE_STAT) begin
         rd_byte = {5'b00000, st_q.mode_taken, st_q.mode};
      end else if (idx == IDX_PLACEMENT) begin
         rd_byte = {st_q.ram_page, st_q.reg_page};
      end else begin
         mapped = 1'b0;
      end
      if (!aligned) begin
         mapped  = 1'b0;
         rd_byte = 8'h00;
      end
   end

   /************************************************
    * Next state
    ************************************************/
   always_comb begin
      st_d     = st_q;
      setup    = PSEL && !PENABLE;
      wr_now   = PSEL && PENABLE && st_q.pready && PWRITE && mapped;
      cap_edge = pins_sync[3:2] & ~st_q.cap_prev;

      if (!st_q.mode_taken) begin
         if (st_q.settle == MODE_SETTLE) begin
            st_d.mode_taken = 1'b1;
            case (pins_sync[1:0])
               PINS_BOOT: begin
                  st_d.mode = MODE_BOOT;
               end
               PINS_TEST: begin
                  st_d.mode = MODE_TEST;
               end
               PINS_SINGLE: begin
                  st_d.mode = MODE_SINGLE;
               end
               default: begin
                  st_d.mode = MODE_EXPANDED;
               end
            endcase
         end else begin
            st_d.settle = st_q.settle + 2'h1;
         end
      end

      // Free-running counter and captures.
      st_d.count    = st_q.count + 16'h0001;
      st_d.cap_prev = pins_sync[3:2];
      if (cap_edge[0]) begin
         st_d.cap1 = st_q.count;
      end
      if (cap_edge[1]) begin
         st_d.cap2 = st_q.count;
      end

      // APB answers one cycle after setup.
      st_d.force_pulse = CMP_RESET;
      st_d.pready      = setup;
      st_d.pslverr     = setup && !mapped;
      st_d.prdata      = setup ? {24'h000000, rd_byte} : 32'h00000000;

      if (wr_now) begin
         if (idx == IDX_PORT_A) begin
            st_d.port_a = wr_byte;
         end else if (idx == IDX_PORT_C) begin
            st_d.port_c = wr_byte;
         end else if (idx == IDX_PORT_B) begin
            st_d.port_b = wr_byte;
         end else if (idx == IDX_DIR_B) begin
            st_d.dir_b = wr_byte;
         end else if (idx == IDX_DIR_C) begin
            st_d.dir_c = wr_byte;
         end else if (idx == IDX_PORT_D) begin
            st_d.port_d = wr_byte;
         end else if (idx == IDX_DIR_D) begin
            st_d.dir_d = wr_byte;
         end else if (idx == IDX_FORCE) begin
            st_d.force_pulse = wr_byte[CMP_MSB:CMP_LSB];
         end else if (idx == IDX_CMP_MASK) begin
            st_d.cmp_mask = wr_byte[CMP_MSB:CMP_LSB];
         end else if (idx == IDX_CMP_DATA) begin
            st_d.cmp_data = wr_byte[CMP_MSB:CMP_LSB];
         end else if (idx == IDX_PLACEMENT) begin
            st_d.ram_page = wr_byte[7:RAM_PAGE_LSB];
            st_d.reg_page = wr_byte[RAM_PAGE_LSB-1:0];
         end
      end

      // Registered decode of the core address.
      st_d.sel_regs = dec_bus.hit_regs;
      st_d.sel_ram  = dec_bus.hit_ram;
      st_d.sel_rom  = dec_bus.hit_rom;
      st_d.sel_ext  = dec_bus.hit_ext;
      st_d.sel_none = !(dec_bus.hit_regs || dec_bus.hit_ram || dec_bus.hit_rom
                        || dec_bus.hit_ext);
      st_d.offset   = dec_bus.offset;
   end

   /************************************************
    * State register
    ************************************************/
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         st_q            <= '0;
         st_q.mode       <= MODE_SINGLE;
         st_q.ram_page   <= RESET_PAGE;
         st_q.reg_page   <= RESET_PAGE;
         st_q.port_a     <= PORT_RESET;
         st_q.cmp_mask   <= CMP_RESET;
         st_q.count      <= COUNT_RESET;
         st_q.sel_none   <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   /************************************************
    * Outputs
    ************************************************/
   assign PRDATA            = st_q.prdata;
   assign PREADY            = st_q.pready;
   assign PSLVERR           = st_q.pslverr;
   assign SEL_REGS          = st_q.sel_regs;
   assign SEL_RAM           = st_q.sel_ram;
   assign SEL_ROM           = st_q.sel_rom;
   assign SEL_EXT           = st_q.sel_ext;
   assign SEL_NONE          = st_q.sel_none;
   assign LOCAL_OFFSET      = st_q.offset;
   assign PORT_A_DATA       = st_q.port_a;
   assign PORT_B_DATA       = st_q.port_b;
   assign PORT_B_DIRECTION  = st_q.dir_b;
   assign PORT_C_DATA       = st_q.port_c;
   assign PORT_C_DIRECTION  = st_q.dir_c;
   assign PORT_D_DATA       = st_q.port_d;
   assign PORT_D_DIRECTION  = st_q.dir_d;
   assign FORCE_COMPARE_BIT = st_q.force_pulse;
   assign COMPARE1_MASK     = st_q.cmp_mask;
   assign COMPARE1_DATA     = st_q.cmp_data;
   assign MODE_LATCHED      = st_q.mode;

endmodule : mmd_top

// File: tb_top.sv
/* Self-checking bench of the decoder top with a core model.
   Assumes zero-wait APB answers and a counter stepping every clock. */
`timescale 1ns/1ps
module tb_top
   import mmd_pkg::*;
;
   logic SYS_CLK = 0, SYS_RST = 1, MODE_A = 0, MODE_B = 1;
   logic PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, err;
   logic SEL_REGS, SEL_RAM, SEL_ROM, SEL_EXT, SEL_NONE;
   logic [1:0]  CAPTURE_IN = 0, MODE_LATCHED;
   logic [4:0]  FORCE_COMPARE_BIT, COMPARE1_MASK, COMPARE1_DATA;
   logic [7:0]  PADDR = 0, LOCAL_OFFSET, place, d8, h1, l1;
   logic [7:0]  PORT_A_DATA, PORT_B_DATA, PORT_B_DIRECTION, PORT_C_DATA;
   logic [7:0]  PORT_C_DIRECTION, PORT_D_DATA, PORT_D_DIRECTION;
   logic [15:0] CORE_ADDR, a, lfsr_q = 16'd73, c1, c2;
   logic [31:0] PWDATA = 0, PRDATA, rd;
   int          mismatches = 0, tests_run = 0;
   logic [7:0]  port_addr [7] = '{8'h00, 8'h0c, 8'h10, 8'h18, 8'h1c, 8'h20, 8'h24};
   logic [55:0] ports;

   assign ports = {PORT_D_DIRECTION, PORT_D_DATA, PORT_C_DIRECTION, PORT_B_DIRECTION,
                   PORT_B_DATA, PORT_C_DATA, PORT_A_DATA};

   always #5 SYS_CLK = ~SYS_CLK;

   mmd_core_model mmd_core_model_inst (.clk(SYS_CLK), .core_addr(CORE_ADDR));
   mmd_top mmd_top_inst (.SYS_CLK, .SYS_RST, .MODE_A, .MODE_B, .CAPTURE_IN, .PSEL,
      .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CORE_ADDR,
      .SEL_REGS, .SEL_RAM, .SEL_ROM, .SEL_EXT, .SEL_NONE, .LOCAL_OFFSET, .PORT_A_DATA,
      .PORT_B_DATA, .PORT_B_DIRECTION, .PORT_C_DATA, .PORT_C_DIRECTION, .PORT_D_DATA,
      .PORT_D_DIRECTION, .FORCE_COMPARE_BIT, .COMPARE1_MASK, .COMPARE1_DATA,
      .MODE_LATCHED);

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   // Expected select bits and local offset of one core address.
   function automatic logic [12:0] expect_dec(input logic [15:0] x, input logic [7:0] p,
                                              input logic [1:0] m);
      if (x[15:12] == p[3:0] && x[11:6] == 6'h00) return {5'h10, 2'h0, x[5:0]};
      if (x[15:12] == p[7:4] && x[11:8] == 4'h0 && x[7:6] != 2'h0)
         return {5'h08, x[7:0] - 8'h40};
      if (m == 2'h0 && x[15:8] == 8'hbf) return {5'h04, x[7:0]};
      if (m[0]) return {5'h02, x[7:0]};
      return {5'h01, 8'h00};
   endfunction : expect_dec

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge SYS_CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= ad;
      PWDATA <= wd;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge SYS_CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         results();
      end
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb

   task automatic pulse();
      @(posedge SYS_CLK);
      CAPTURE_IN <= 2'h3;
      @(posedge SYS_CLK);
      CAPTURE_IN <= 2'h0;
   endtask : pulse

   task automatic read_caps();
      apb(0, 8'h40, 0); h1 = rd[7:0];
      apb(0, 8'h44, 0); c1 = {h1, rd[7:0]};
      apb(0, 8'h48, 0); h1 = rd[7:0];
      apb(0, 8'h4c, 0); c2 = {h1, rd[7:0]};
   endtask : read_caps

   initial begin
      repeat (20000) @(posedge SYS_CLK);
      mismatches++;
      results();
   end

   initial begin
      for (int m = 0; m < 4; m++) begin
         @(posedge SYS_CLK);
         SYS_RST <= 1'b1;
         MODE_B <= m[1];
         MODE_A <= m[0];
         repeat (2) @(posedge SYS_CLK);
         SYS_RST <= 1'b0;
         repeat (6) @(posedge SYS_CLK);
         check({30'h0, MODE_LATCHED}, m);
         apb(0, 8'hf0, 0); check(rd, {29'h0, 1'b1, m[1:0]});
         place = (m == 0) ? 8'h00 : (m == 1) ? 8'h33 : lfsr_q[7:0];
         if (m != 0) apb(1, 8'hf4, {24'h0, place});
         apb(0, 8'hf4, 0); check(rd, {24'h0, place});
         repeat (64) begin
            lfsr_q = lfsr_next(lfsr_q);
            a = lfsr_q[15] ? {lfsr_q[14] ? place[3:0] : place[7:4], 4'h0, lfsr_q[7:0]}
              : lfsr_q[14] ? {8'hbf, lfsr_q[7:0]} : lfsr_q;
            mmd_core_model_inst.issue(a);
            @(posedge SYS_CLK);
            #1;
            check({SEL_REGS, SEL_RAM, SEL_ROM, SEL_EXT, SEL_NONE, LOCAL_OFFSET},
                  expect_dec(a, place, m[1:0]));
         end
      end
      // Register table: reset zero, write then read back each latch.
      foreach (port_addr[i]) begin
         lfsr_q = lfsr_next(lfsr_q);
         apb(0, port_addr[i], 0); check(rd, 0);
         apb(1, port_addr[i], {24'h0, lfsr_q[7:0]});
         apb(0, port_addr[i], 0); check(rd, {24'h0, lfsr_q[7:0]});
         check({24'h0, ports[i*8 +: 8]}, {24'h0, lfsr_q[7:0]});
      end
      apb(0, 8'h04, 0); check({31'h0, err}, 1);
      apb(1, 8'h01, 32'hff); check({31'h0, err}, 1);
      apb(1, 8'h2c, 32'hff);
      #1 check({27'h0, FORCE_COMPARE_BIT}, 32'h1f);
      apb(0, 8'h2c, 0); check(rd, 0);
      foreach (port_addr[i]) begin
         lfsr_q = lfsr_next(lfsr_q);
         apb(1, 8'h30, {24'h0, lfsr_q[7:0]});
         apb(0, 8'h30, 0); check(rd, {24'h0, lfsr_q[7:3], 3'h0});
         check({27'h0, COMPARE1_MASK}, {27'h0, lfsr_q[7:3]});
         apb(1, 8'h34, {24'h0, ~lfsr_q[7:0]});
         apb(0, 8'h34, 0); check(rd, {24'h0, ~lfsr_q[7:3], 3'h0});
         check({27'h0, COMPARE1_DATA}, {27'h0, ~lfsr_q[7:3]});
      end
      apb(0, 8'h3c, 0); l1 = rd[7:0];
      apb(0, 8'h38, 0);
      apb(0, 8'h3c, 0); d8 = rd[7:0] - l1;
      check(d8, 8'h06);
      apb(0, 8'h38, 0); h1 = rd[7:0];
      repeat (253) @(posedge SYS_CLK);
      apb(0, 8'h38, 0); d8 = rd[7:0] - h1;
      check(d8, 8'h01);
      pulse();
      repeat (10) @(posedge SYS_CLK);
      read_caps();
      check(c2, c1);
      a = c1;
      repeat (276) @(posedge SYS_CLK);
      pulse();
      repeat (10) @(posedge SYS_CLK);
      read_caps();
      check(c1 - a, 16'd300);
      results();
   end
endmodule : tb_top
